// ### src/acs_pkg.sv
// package: register map, fields and state of the aux converter sequencer
package acs_pkg;
   localparam logic [7:0]  OFS_CTRL1   = 8'h90;
   localparam logic [7:0]  OFS_CTRL2   = 8'h94;
   localparam logic [7:0]  OFS_STATUS  = 8'h9c;
   localparam logic [7:0]  OFS_RESULT0 = 8'ha0;
   localparam logic [15:0] CTRL1_RESET = 16'h0000;
   localparam logic [15:0] CTRL2_RESET = 16'h0000;
   localparam int          NUM_CHAN    = 5;
   localparam int          RES_W       = 12;
   localparam logic [1:0]  MASK_IGNORE = 2'h0;
   localparam logic [1:0]  MASK_INHIB  = 2'h1;
   localparam logic [1:0]  MASK_TRIG   = 2'h3;
   // continuous rate: slowest set rate and the core clock rate
   localparam int          CLK_HZ      = 25_000_000;
   localparam int          SLOW_HZ     = 1;
   localparam int          SLOW_CYCLES = CLK_HZ / SLOW_HZ;

   // control one: bit 15 down to bit 0
   typedef struct packed {
      logic       en;
      logic       cont;
      logic       poll;
      logic       hib;
      logic [3:0] rsv_hi;
      logic [4:0] sel;     // [4] temp .. [0] aux four
      logic [2:0] rsv_lo;
   } acs_ctrl1_type;

   typedef struct packed {
      logic [1:0] rsv_a;
      logic [1:0] mask_mode;
      logic       rsv_b;
      logic [2:0] rate;
      logic [6:0] rsv_c;
      logic       hold;
   } acs_ctrl2_type;

   typedef enum {ST_IDLE, ST_ISSUE, ST_WAIT} acs_fsm_type;

   typedef struct packed {
      acs_ctrl1_type                       c1;
      acs_ctrl2_type                       c2;
      acs_fsm_type                         fsm;
      logic [2:0]                          chan;
      logic [NUM_CHAN-1:0][RES_W-1:0]      res;
      logic [NUM_CHAN-1:0]                 fresh;
      logic [31:0]                         tmr;
      logic                                pend;
      logic                                msk_meta;
      logic                                msk_sync;
      logic                                msk_prev;
      logic                                pready;
      logic                                pslverr;
      logic [31:0]                         prdata;
      logic                                start;
      logic                                conv_on;
      logic                                busy;
   } acs_state_type;
endpackage : acs_pkg

// ### src/acs_sequencer.sv
// aux converter sequencer: apb registers, channel scan and trigger logic
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
// Overview of operation
// [RULE1] no conversion starts while the enable bit 15 is clear
// [RULE2] mode bit 14: zero polls, one runs continuously
// [RULE3] writing one to poll bit 13 starts one set over enabled channels
// [RULE4] poll bit clears itself when that set has finished
// [RULE5] hibernate with bit 12 set disables the converter, else unaffected
// [RULE6] temperature channel measured only when bit 7 set
// [RULE7] battery channel measured only when bit 6 set
// [RULE8] line channel measured only when bit 5 set
// [RULE9] usb channel measured only when bit 4 set
// [RULE10] aux four input measured only when bit 3 set
// [RULE11] power state machine reset returns every control field to zero
// [RULE12] continuous sets repeat at 1,4,8..256 per second by rate code
// [RULE13] hold option delays new sets until previous results are read
// [RULE14] mask input ignored, inhibits sets, or triggers sets itself
// [RULE15] results are 12-bit values, zero is 0V, all ones the reference
module acs_sequencer #(
   parameter int SLOW_PERIOD = acs_pkg::SLOW_CYCLES
) (
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        psm_reset,
   input  wire logic        hibernate,
   input  wire logic        mask_in,
   input  wire logic        conv_done,
   input  wire logic [11:0] conv_data,
   output logic             conv_start,
   output logic [2:0]       conv_channel,
   output logic             conv_on,
   output logic             set_busy
);
   acs_pkg::acs_state_type s;
   acs_pkg::acs_state_type next_s;
   logic                   run_ok;
   logic                   hold_block;
   logic                   acc_first;
   logic                   acc_done;
   logic                   wr;
   logic                   rd;

   // period of one set for a rate code, rounded down to whole cycles
   function automatic logic [31:0] period(input logic [2:0] code);
      logic [31:0] base;
      base = 32'(SLOW_PERIOD);
      if (code == 3'h0) begin
         period = base;
      end else begin
         period = base >> (32'(code) + 32'h1);
      end
   endfunction : period

   // converter may run only when enabled, awake and not masked
   always_comb begin
      run_ok = s.c1.en                                  // RULE1
         && !(hibernate && s.c1.hib)                    // RULE5
         && !(s.c2.mask_mode == acs_pkg::MASK_INHIB
              && s.msk_sync);                           // RULE14
      hold_block = s.c2.hold && (|s.fresh);             // RULE13
   end

   // apb phases: one wait state, actions on the completing edge
   assign acc_first = psel && penable && !s.pready;
   assign acc_done  = psel && penable && s.pready;
   assign wr        = acc_done && pwrite;
   assign rd        = acc_done && !pwrite;

   always_comb begin
      next_s          = s;
      next_s.pready   = 1'b0;
      next_s.start    = 1'b0;
      // mask pin synchroniser, edge taken after the second stage
      next_s.msk_meta = mask_in;
      next_s.msk_sync = s.msk_meta;
      next_s.msk_prev = s.msk_sync;

      // read data and error are registered on the same edge that raises pready
      if (acc_first) begin
         next_s.pready  = 1'b1;
         next_s.pslverr = 1'b0;
         next_s.prdata  = 32'h0;
         if (paddr == acs_pkg::OFS_CTRL1) begin
            next_s.prdata = {16'h0, s.c1};
         end else if (paddr == acs_pkg::OFS_CTRL2) begin
            next_s.prdata = {16'h0, s.c2};
         end else if (paddr == acs_pkg::OFS_STATUS) begin
            next_s.prdata = {16'h0, 7'h0, s.busy, 3'h0, s.fresh};
         end else if (paddr >= acs_pkg::OFS_RESULT0
                      && paddr < acs_pkg::OFS_RESULT0 + 8'h14
                      && paddr[1:0] == 2'h0) begin
            next_s.prdata = {20'h0,
               s.res[3'(paddr[4:2] - acs_pkg::OFS_RESULT0[4:2])]}; // RULE15
         end else begin
            next_s.pslverr = 1'b1;
         end
      end

      // reading a result releases it for the hold option
      if (rd && paddr >= acs_pkg::OFS_RESULT0
          && paddr < acs_pkg::OFS_RESULT0 + 8'h14) begin
         next_s.fresh[3'(paddr[4:2] - acs_pkg::OFS_RESULT0[4:2])] = 1'b0;
      end

      // continuous timer, reloaded at each expiry from the rate code
      if (!run_ok || !s.c1.cont
          || s.c2.mask_mode == acs_pkg::MASK_TRIG) begin
         next_s.tmr = period(s.c2.rate);
      end else if (s.tmr == 32'h0) begin
         next_s.tmr  = period(s.c2.rate) - 32'h1;          // RULE12
         next_s.pend = 1'b1;                                // RULE2
      end else begin
         next_s.tmr = s.tmr - 32'h1;
      end
      if (s.c2.mask_mode == acs_pkg::MASK_TRIG
          && s.msk_sync && !s.msk_prev) begin
         next_s.pend = 1'b1;                                // RULE14
      end

      // set scan: walk the channels, convert only the selected ones
      case (s.fsm)
         acs_pkg::ST_IDLE: begin
            if (run_ok && !hold_block) begin
               if (s.c2.mask_mode == acs_pkg::MASK_TRIG
                   || s.c1.cont) begin
                  if (s.pend) begin
                     next_s.pend = 1'b0;
                     next_s.fsm  = acs_pkg::ST_ISSUE;
                     next_s.chan = 3'h0;
                     next_s.busy = 1'b1;
                  end
               end else if (s.c1.poll) begin                // RULE3
                  next_s.fsm  = acs_pkg::ST_ISSUE;
                  next_s.chan = 3'h0;
                  next_s.busy = 1'b1;
               end
            end
         end
         acs_pkg::ST_ISSUE: begin
            if (!run_ok) begin
               next_s.fsm  = acs_pkg::ST_IDLE;
               next_s.busy = 1'b0;
            end else if (s.chan == 3'(acs_pkg::NUM_CHAN)) begin
               next_s.fsm     = acs_pkg::ST_IDLE;
               next_s.busy    = 1'b0;
               next_s.c1.poll = 1'b0;                       // RULE4
            end else if (s.c1.sel[s.chan]) begin // RULE6 RULE7 RULE8 RULE9 RULE10
               next_s.start = 1'b1;
               next_s.fsm   = acs_pkg::ST_WAIT;
            end else begin
               next_s.chan = s.chan + 3'h1;
            end
         end
         acs_pkg::ST_WAIT: begin
            if (!run_ok) begin
               next_s.fsm  = acs_pkg::ST_IDLE;
               next_s.busy = 1'b0;
            end else if (conv_done) begin
               next_s.res[s.chan]   = conv_data;            // RULE15
               next_s.fresh[s.chan] = 1'b1;                 // RULE13
               next_s.chan          = s.chan + 3'h1;
               next_s.fsm           = acs_pkg::ST_ISSUE;
            end
         end
         default: begin
            next_s.fsm = acs_pkg::ST_IDLE;
         end
      endcase

      // software writes come after the self clear, so a new poll wins
      if (wr && paddr == acs_pkg::OFS_CTRL1) begin
         next_s.c1        = acs_pkg::acs_ctrl1_type'(pwdata[15:0]);
         next_s.c1.rsv_hi = 4'h0;
         next_s.c1.rsv_lo = 3'h0;
         // a poll only counts in polling mode, else it would never clear
         next_s.c1.poll = pwdata[13] && !pwdata[14]
            && s.c2.mask_mode != acs_pkg::MASK_TRIG;        // RULE3
         if (!pwdata[13] && s.c1.poll) begin
            next_s.c1.poll = s.c1.poll && next_s.c1.poll;
         end
      end
      if (wr && paddr == acs_pkg::OFS_CTRL2) begin
         next_s.c2       = acs_pkg::acs_ctrl2_type'(pwdata[15:0]);
         next_s.c2.rsv_a = 2'h0;
         next_s.c2.rsv_b = 1'b0;
         next_s.c2.rsv_c = 7'h0;
      end

      // power state machine reset clears every control field
      if (psm_reset) begin
         next_s.c1   = acs_pkg::CTRL1_RESET;                // RULE11
         next_s.c2   = acs_pkg::CTRL2_RESET;                // RULE11
         next_s.pend = 1'b0;
      end
      next_s.conv_on = run_ok;
   end

   // one register for the whole state
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s        <= '0;
         s.c1     <= acs_pkg::CTRL1_RESET;
         s.c2     <= acs_pkg::CTRL2_RESET;
         s.fsm    <= acs_pkg::ST_IDLE;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state register
   assign pready       = s.pready;
   assign prdata       = s.prdata;
   assign pslverr      = s.pslverr;
   assign conv_start   = s.start;
   assign conv_channel = s.chan;
   assign conv_on      = s.conv_on;
   assign set_busy     = s.busy;

   // checks
   chk_start_enabled: assert property (                   // RULE1
      @(posedge core_clk) disable iff (!reset_n)
      s.start |-> $past(s.c1.en))
      else $error("conversion started while disabled");

   chk_poll_selfclear: assert property (                  // RULE4
      @(posedge core_clk) disable iff (!reset_n)
      (s.fsm == acs_pkg::ST_ISSUE && run_ok && !wr && !psm_reset
       && s.chan == 3'(acs_pkg::NUM_CHAN)) |=> !s.c1.poll && !s.busy)
      else $error("poll bit not cleared at end of set");

   chk_poll_starts: assert property (                     // RULE2 RULE3
      @(posedge core_clk) disable iff (!reset_n)
      (s.fsm == acs_pkg::ST_IDLE && run_ok && !hold_block && s.c1.poll
       && !s.c1.cont && s.c2.mask_mode != acs_pkg::MASK_TRIG)
      |=> s.fsm == acs_pkg::ST_ISSUE && s.chan == 3'h0)
      else $error("poll request did not start a set");

   chk_hib_disable: assert property (                     // RULE5
      @(posedge core_clk) disable iff (!reset_n)
      (hibernate && s.c1.hib) |=> !s.start && !s.conv_on)
      else $error("converter active in hibernate");

   chk_channel_sel: assert property (      // RULE6 RULE7 RULE8 RULE9 RULE10
      @(posedge core_clk) disable iff (!reset_n)
      s.start |-> $past(s.c1.sel[s.chan]))
      else $error("unselected channel converted");

   chk_psm_reset: assert property (                       // RULE11
      @(posedge core_clk) disable iff (!reset_n)
      psm_reset |=> s.c1 == acs_pkg::CTRL1_RESET
                    && s.c2 == acs_pkg::CTRL2_RESET)
      else $error("control fields not cleared by state machine");

   chk_rate_reload: assert property (                     // RULE12
      @(posedge core_clk) disable iff (!reset_n)
      (s.tmr == 32'h0 && run_ok && s.c1.cont
       && s.c2.mask_mode != acs_pkg::MASK_TRIG)
      |=> s.pend && s.tmr == period($past(s.c2.rate)) - 32'h1)
      else $error("continuous timer reload wrong");

   chk_hold_read: assert property (                       // RULE13
      @(posedge core_clk) disable iff (!reset_n)
      (s.fsm == acs_pkg::ST_IDLE && hold_block)
      |=> s.fsm == acs_pkg::ST_IDLE)
      else $error("set started before results were read");

   chk_mask_inhib: assert property (                      // RULE14
      @(posedge core_clk) disable iff (!reset_n)
      (s.c2.mask_mode == acs_pkg::MASK_INHIB && s.msk_sync)
      |=> !s.start)
      else $error("conversion while mask inhibits");

   chk_result_store: assert property (                    // RULE15
      @(posedge core_clk) disable iff (!reset_n)
      (s.fsm == acs_pkg::ST_WAIT && run_ok && conv_done)
      |=> s.res[$past(s.chan)] == $past(conv_data)
          && s.fresh[$past(s.chan)])
      else $error("result not stored");

   chk_apb_wait: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      acc_first |=> s.pready ##1 !s.pready)
      else $error("apb answer not one wait state");

   cov_poll_set: cover property (
      @(posedge core_clk) disable iff (!reset_n)
      s.c1.poll ##[1:200] !s.c1.poll);
   cov_cont_set: cover property (
      @(posedge core_clk) disable iff (!reset_n)
      s.c1.cont && s.start);
   cov_mask_trig: cover property (
      @(posedge core_clk) disable iff (!reset_n)
      s.c2.mask_mode == acs_pkg::MASK_TRIG && s.start);
   cov_hold_wait: cover property (
      @(posedge core_clk) disable iff (!reset_n)
      hold_block && s.pend);
endmodule : acs_sequencer

// ### testbench/acs_sequencer_tb.sv
// self-checking bench for the aux converter sequencer
`timescale 1ns/1ps
module acs_sequencer_tb;
   localparam int SLOW = 512;  // shortened 1 Hz period, rate code 1 -> 128
   logic        core_clk     = 1'b0;
   logic        reset_n      = 1'b0;
   logic        psel         = 1'b0;
   logic        penable      = 1'b0;
   logic        pwrite       = 1'b0;
   logic [7:0]  paddr        = 8'h00;
   logic [31:0] pwdata       = 32'h0;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic        psm_reset    = 1'b0;
   logic        hibernate    = 1'b0;
   logic        mask_in      = 1'b0;
   logic        conv_done    = 1'b0;
   logic [11:0] conv_data    = 12'h000;
   logic        conv_start;
   logic [2:0]  conv_channel;
   logic        conv_on;
   logic        set_busy;
   logic        d1           = 1'b0;
   logic        d2           = 1'b0;
   logic [2:0]  last_ch      = 3'h0;
   logic [31:0] rdata;
   logic        rerr;
   int          n_errors     = 0;
   int          samples_checked = 0;
   int          starts       = 0;
   int          cycles       = 0;
   int          s0;

   acs_sequencer #(.SLOW_PERIOD(SLOW)) u_dut (
      .core_clk(core_clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .psm_reset(psm_reset), .hibernate(hibernate),
      .mask_in(mask_in), .conv_done(conv_done), .conv_data(conv_data),
      .conv_start(conv_start), .conv_channel(conv_channel),
      .conv_on(conv_on), .set_busy(set_busy));

   initial begin
      forever #20 core_clk = ~core_clk;
   end

   // converter stand-in: answers three cycles after each start
   always @(posedge core_clk) begin
      d1        <= conv_start;
      d2        <= d1;
      conv_done <= d2;
      conv_data <= {9'h1ff, conv_channel};  // near full scale, tagged by ch
      if (conv_start === 1'b1) begin
         starts  <= starts + 1;
         last_ch <= conv_channel;
      end
   end

   // hang guard: whole run needs well under 5000 cycles
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : cmp

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int i;
      @(posedge core_clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge core_clk);
         if (pready === 1'b1) break;
      end
      if (pready !== 1'b1) begin
         n_errors++;
         $display("[FAIL] %0t apb transfer got no answer", $time);
      end
      rdata = prdata;
      rerr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      cmp(rdata, exp, "read");
   endtask : rd

   // wait for a set to begin (mask trigger needs sync time), then to end
   task automatic wait_idle();
      int i;
      for (i = 0; i < 20; i++) begin
         @(posedge core_clk);
         if (set_busy === 1'b1) break;
      end
      for (i = 0; i < 200; i++) begin
         @(posedge core_clk);
         if (set_busy === 1'b0) break;
      end
      if (i == 200) begin
         n_errors++;
         $display("[FAIL] %0t set never finished", $time);
      end
   endtask : wait_idle

   task automatic t_reset();
      rd(acs_pkg::OFS_CTRL1, 32'h0);
      rd(acs_pkg::OFS_CTRL2, 32'h0);
      rd(8'h80, 32'h0);
      cmp(32'(rerr), 32'h1, "unmapped error");
      s0 = starts;
      apb(1'b1, acs_pkg::OFS_CTRL1, 32'h20f8);
      repeat (30) @(posedge core_clk);
      cmp(starts - s0, 0, "start while disabled");
      $display("test reset/disable done");
   endtask : t_reset

   task automatic t_channels();
      for (int k = 0; k < 5; k++) begin
         s0 = starts;
         apb(1'b1, acs_pkg::OFS_CTRL1, 32'ha000 | (32'h8 << k));
         wait_idle();
         cmp(starts - s0, 1, "one start");
         cmp(32'(last_ch), k, "channel");
         rd(acs_pkg::OFS_CTRL1, 32'h8000 | (32'h8 << k));
         rd(acs_pkg::OFS_RESULT0 + 8'(4 * k), {20'h0, 9'h1ff, 3'(k)});
      end
      s0 = starts;
      apb(1'b1, acs_pkg::OFS_CTRL1, 32'ha0f8);
      wait_idle();
      cmp(starts - s0, 5, "full set");
      $display("test channels done");
   endtask : t_channels

   // results still unread from the full set block any new set
   task automatic t_hold();
      apb(1'b1, acs_pkg::OFS_CTRL2, 32'h0001);
      s0 = starts;
      apb(1'b1, acs_pkg::OFS_CTRL1, 32'ha008);
      repeat (30) @(posedge core_clk);
      cmp(starts - s0, 0, "held set");
      apb(1'b1, acs_pkg::OFS_CTRL1, 32'h8008);
      for (int k = 0; k < 5; k++) apb(1'b0, acs_pkg::OFS_RESULT0 + 8'(4 * k), 0);
      s0 = starts;
      apb(1'b1, acs_pkg::OFS_CTRL1, 32'ha008);
      wait_idle();
      cmp(starts - s0, 1, "set after read");
      apb(1'b1, acs_pkg::OFS_CTRL2, 32'h0000);
      $display("test hold done");
   endtask : t_hold

   task automatic t_mask();
      apb(1'b1, acs_pkg::OFS_CTRL2, 32'h1000);
      mask_in <= 1'b1;
      s0 = starts;
      apb(1'b1, acs_pkg::OFS_CTRL1, 32'ha008);
      repeat (30) @(posedge core_clk);
      cmp(starts - s0, 0, "inhibited");
      apb(1'b1, acs_pkg::OFS_CTRL1, 32'h8008);
      mask_in <= 1'b0;
      apb(1'b1, acs_pkg::OFS_CTRL2, 32'h3000);
      s0 = starts;
      apb(1'b1, acs_pkg::OFS_CTRL1, 32'ha008);
      repeat (30) @(posedge core_clk);
      cmp(starts - s0, 0, "poll in trigger mode");
      mask_in <= 1'b1;
      wait_idle();
      cmp(starts - s0, 1, "mask trigger");
      mask_in <= 1'b0;
      apb(1'b1, acs_pkg::OFS_CTRL2, 32'h0000);
      $display("test mask done");
   endtask : t_mask

   task automatic t_cont();
      apb(1'b1, acs_pkg::OFS_CTRL2, 32'h0100);
      apb(1'b1, acs_pkg::OFS_CTRL1, 32'hc008);
      s0 = starts;
      repeat (600) @(posedge core_clk);
      cmp(32'(starts - s0 inside {[4:5]}), 32'h1, "rate 1");
      apb(1'b1, acs_pkg::OFS_CTRL1, 32'hd008);
      hibernate <= 1'b1;
      repeat (20) @(posedge core_clk);
      s0 = starts;
      repeat (300) @(posedge core_clk);
      cmp(starts - s0, 0, "hibernate off");
      cmp(32'(conv_on), 32'h0, "conv_on hib");
      apb(1'b1, acs_pkg::OFS_CTRL1, 32'hc008);
      s0 = starts;
      repeat (300) @(posedge core_clk);
      cmp(32'(starts - s0 >= 2), 32'h1, "hibernate run");
      cmp(32'(conv_on), 32'h1, "conv_on run");
      hibernate <= 1'b0;
      psm_reset <= 1'b1;
      @(posedge core_clk);
      psm_reset <= 1'b0;
      rd(acs_pkg::OFS_CTRL1, 32'h0);
      rd(acs_pkg::OFS_CTRL2, 32'h0);
      $display("test continuous done");
   endtask : t_cont

   initial begin
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      t_reset();
      t_channels();
      t_hold();
      t_mask();
      t_cont();
      report_and_stop();
   end
endmodule : acs_sequencer_tb
